/* ast_pkg.sv */
// Constants and types shared by the asynchronous serial transmitter.
// Assumes one 25 MHz clock and an external bit-rate tick source.
package ast_pkg;
    localparam int AST_ADDR_W = 4;
    localparam int AST_DATA_W = 8;
    localparam int AST_CHAR_W = 9;
    localparam int AST_CNT_W = 4;
    localparam logic [3:0] AST_TX_STATUS = 4'h0;
    localparam logic [3:0] AST_RX_STATUS = 4'h1;
    localparam logic [3:0] AST_BAUD_CTRL = 4'h2;
    localparam logic [3:0] AST_TX_HOLD = 4'h3;
    localparam logic [3:0] AST_DIV_HIGH = 4'h4;
    localparam logic [3:0] AST_DIV_LOW = 4'h5;
    localparam logic [3:0] AST_IRQ_FLAGS = 4'h6;
    localparam logic [3:0] AST_IRQ_EN = 4'h7;
    localparam logic [3:0] AST_IRQ_PRIO = 4'h8;
    localparam logic [3:0] AST_IRQ_CTRL = 4'h9;
    localparam int AST_NINE_POS = 6;
    localparam int AST_ENABLE_POS = 5;
    localparam int AST_CLOCKED_POS = 4;
    localparam int AST_SPEED_POS = 2;
    localparam int AST_EMPTY_POS = 1;
    localparam int AST_NINTH_POS = 0;
    localparam int AST_PORT_ON_POS = 7;
    localparam int AST_INVERT_POS = 4;
    localparam int AST_WIDE_POS = 3;
    localparam int AST_TX_IRQ_POS = 4;
    localparam int AST_GLOBAL_POS = 7;
    localparam int AST_PERIPH_POS = 6;
    localparam logic [7:0] AST_TXS_MASK = 8'hFD;
    localparam logic [7:0] AST_RXS_MASK = 8'hF8;
    localparam logic [7:0] AST_BDC_MASK = 8'h3B;
    localparam logic [7:0] AST_CTRL_MASK = 8'hC0;
    localparam logic [7:0] AST_REG_RST = 8'h00;
    localparam logic AST_MARK = 1'b1;
    localparam logic AST_SPACE = 1'b0;
    typedef enum logic [1:0] {
        AST_IDLE = 2'b00,
        AST_START = 2'b01,
        AST_DATA = 2'b11,
        AST_STOP = 2'b10
    } ast_state_e;
    typedef struct packed {
        logic [15:0] divisor;
        logic high_speed;
        logic wide_counter;
    } ast_baud_s;
    typedef struct packed {
        logic ninth;
        logic [7:0] low;
    } ast_char_s;
endpackage

/* ast_rx_model.sv */
// Behavioural remote receiver that watches the serial output pin.
// Assumes the bench restarts its bit ticks at every frame start.
`timescale 1ns/1ps
module ast_rx_model
    import ast_pkg::*;
#(
    parameter int BIT_P = 16
)
(
    input wire logic mclk,
    input wire logic line,
    input wire logic invert,
    input wire logic nine,
    output logic [8:0] rx_char,
    output logic rx_stop_ok,
    output logic [7:0] rx_count
);
    logic [8:0] shift;
    logic lvl;
    int i;
    assign lvl = line ^ invert;
    initial
    begin
        rx_char = '0;
        rx_stop_ok = 1'b0;
        rx_count = '0;
    end
    // Samples each bit in its middle and reports the stop level.
    always
    begin
        @(posedge mclk);
        if (lvl === AST_SPACE)
        begin
            repeat (BIT_P / 2) @(posedge mclk);
            if (lvl === AST_SPACE)
            begin
                shift = '0;
                for (i = 0; i < 9; i++)
                begin
                    if (i < 8 || nine)
                    begin
                        repeat (BIT_P) @(posedge mclk);
                        shift[i] = lvl;
                    end
                end
                repeat (BIT_P) @(posedge mclk);
                rx_char <= shift;
                rx_stop_ok <= (lvl === AST_MARK);
                rx_count <= rx_count + 8'h01;
            end
        end
    end
endmodule

/* ast_shifter.sv */
// Transmit shift engine: start bit, 8 or 9 data bits, stop bit.
// Assumes tick is a one-cycle bit-rate pulse from the same clock.
`timescale 1ns/1ps
module ast_shifter
    import ast_pkg::*;
#(
    parameter int CHAR_W = AST_CHAR_W
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic load,
    input wire logic [CHAR_W-1:0] char_in,
    input wire logic nine,
    input wire logic tick,
    output logic line,
    output logic busy,
    output logic frame_done
);
    ast_state_e state_reg, state_next;
    logic [CHAR_W-1:0] shift_reg, shift_next;
    logic [AST_CNT_W-1:0] cnt_reg, cnt_next;
    logic line_reg, line_next;
    logic done_reg, done_next;
    logic [AST_CNT_W-1:0] last_bit;

    assign last_bit = nine ? AST_CNT_W'(8) : AST_CNT_W'(7);

    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        line_next = line_reg;
        done_next = 1'b0;
        case (state_reg)
            AST_IDLE:
            begin
                line_next = AST_MARK;
                if (load)
                begin
                    state_next = AST_START;
                    shift_next = char_in;
                    cnt_next = '0;
                    line_next = AST_SPACE;
                end
            end
            AST_START:
            begin
                if (tick)
                begin
                    state_next = AST_DATA;
                    line_next = shift_reg[0];
                    shift_next = shift_reg >> 1;
                end
            end
            AST_DATA:
            begin
                if (tick && cnt_reg == last_bit)
                begin
                    state_next = AST_STOP;
                    line_next = AST_MARK;
                end
                else if (tick)
                begin
                    cnt_next = cnt_reg + AST_CNT_W'(1);
                    line_next = shift_reg[0];
                    shift_next = shift_reg >> 1;
                end
            end
            default:
            begin
                if (tick)
                begin
                    state_next = AST_IDLE;
                    done_next = 1'b1;
                end
            end
        endcase
        if (clear)
        begin
            state_next = AST_IDLE;
            line_next = AST_MARK;
            done_next = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            state_reg <= AST_IDLE;
            shift_reg <= '0;
            cnt_reg <= '0;
            line_reg <= AST_MARK;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            line_reg <= line_next;
            done_reg <= done_next;
        end
    end

    assign line = line_reg;
    assign busy = state_reg != AST_IDLE;
    assign frame_done = done_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    bit_hold_a: assert property (
        (busy && !tick && !clear) |=> $stable(line_reg))
        else $error("Bit level changed without a tick.");
    start_space_a: assert property (
        (state_reg == AST_START) |-> (line_reg == AST_SPACE))
        else $error("Start bit is not space.");
    ninth_count_a: assert property (
        (state_reg == AST_DATA && tick && !clear && nine && cnt_reg == 4'h7)
        |=> (state_reg == AST_DATA && cnt_reg == 4'h8))
        else $error("Ninth data bit was skipped.");
endmodule

/* ast_uart_tx.sv */
// Asynchronous serial transmitter with its control registers.
// Assumes a plain register port and a bit tick from a baud generator.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module ast_uart_tx
    import ast_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [AST_ADDR_W-1:0] reg_addr,
    input wire logic [AST_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [AST_DATA_W-1:0] reg_rdata,
    input wire logic bit_tick,
    output ast_baud_s baud_cfg,
    output logic baud_restart,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic tx_irq
);
    logic [7:0] tx_status_reg, tx_status_next;
    logic [7:0] rx_status_reg, rx_status_next;
    logic [7:0] baud_ctrl_reg, baud_ctrl_next;
    logic [7:0] div_high_reg, div_high_next;
    logic [7:0] div_low_reg, div_low_next;
    logic [7:0] irq_en_reg, irq_en_next;
    logic [7:0] irq_prio_reg, irq_prio_next;
    logic [7:0] irq_ctrl_reg, irq_ctrl_next;
    ast_char_s hold_reg, hold_next;
    logic hold_full_reg, hold_full_next;
    logic flag_reg, flag_next;
    logic [7:0] rdata_reg, rdata_next;
    logic out_reg, out_next;
    logic oe_reg, oe_next;
    logic irq_reg, irq_next;
    logic restart_reg, restart_next;
    logic tx_on, tx_on_next;
    logic serial_port_on, invert_eff;
    logic load_shift;
    logic shift_line, shift_busy, shift_done;

    function automatic logic hits(
        input logic [AST_ADDR_W-1:0] a,
        input logic [AST_ADDR_W-1:0] t
    );
        return a == t;
    endfunction

    always_comb
    begin
        tx_status_next = tx_status_reg;
        rx_status_next = rx_status_reg;
        baud_ctrl_next = baud_ctrl_reg;
        div_high_next = div_high_reg;
        div_low_next = div_low_reg;
        irq_en_next = irq_en_reg;
        irq_prio_next = irq_prio_reg;
        irq_ctrl_next = irq_ctrl_reg;
        if (reg_write)
        begin
            if (hits(reg_addr, AST_TX_STATUS))
            begin
                tx_status_next = reg_wdata & AST_TXS_MASK;
            end
            else if (hits(reg_addr, AST_RX_STATUS))
            begin
                rx_status_next = reg_wdata & AST_RXS_MASK;
            end
            else if (hits(reg_addr, AST_BAUD_CTRL))
            begin
                baud_ctrl_next = reg_wdata & AST_BDC_MASK;
            end
            else if (hits(reg_addr, AST_DIV_HIGH))
            begin
                div_high_next = reg_wdata;
            end
            else if (hits(reg_addr, AST_DIV_LOW))
            begin
                div_low_next = reg_wdata;
            end
            else if (hits(reg_addr, AST_IRQ_EN))
            begin
                irq_en_next = reg_wdata;
            end
            else if (hits(reg_addr, AST_IRQ_PRIO))
            begin
                irq_prio_next = reg_wdata;
            end
            else if (hits(reg_addr, AST_IRQ_CTRL))
            begin
                irq_ctrl_next = reg_wdata & AST_CTRL_MASK;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            tx_status_reg <= AST_REG_RST;
            rx_status_reg <= AST_REG_RST;
            baud_ctrl_reg <= AST_REG_RST;
            div_high_reg <= AST_REG_RST;
            div_low_reg <= AST_REG_RST;
            irq_en_reg <= AST_REG_RST;
            irq_prio_reg <= AST_REG_RST;
            irq_ctrl_reg <= AST_REG_RST;
        end
        else
        begin
            tx_status_reg <= tx_status_next;
            rx_status_reg <= rx_status_next;
            baud_ctrl_reg <= baud_ctrl_next;
            div_high_reg <= div_high_next;
            div_low_reg <= div_low_next;
            irq_en_reg <= irq_en_next;
            irq_prio_reg <= irq_prio_next;
            irq_ctrl_reg <= irq_ctrl_next;
        end
    end

    assign serial_port_on = rx_status_reg[AST_PORT_ON_POS];
    assign tx_on = tx_status_reg[AST_ENABLE_POS]
        && !tx_status_reg[AST_CLOCKED_POS]
        && serial_port_on;
    assign tx_on_next = tx_status_next[AST_ENABLE_POS]
        && !tx_status_next[AST_CLOCKED_POS]
        && rx_status_next[AST_PORT_ON_POS];
    assign invert_eff = baud_ctrl_reg[AST_INVERT_POS]
        && !tx_status_reg[AST_CLOCKED_POS];
    assign load_shift = hold_full_reg && !shift_busy && tx_on;

    ast_shifter #(
        .CHAR_W(AST_CHAR_W)
    ) u_shifter (
        .mclk(mclk),
        .nrst(nrst),
        .clear(!tx_on),
        .load(load_shift),
        .char_in(hold_reg),
        .nine(tx_status_reg[AST_NINE_POS]),
        .tick(bit_tick && !restart_reg),
        .line(shift_line),
        .busy(shift_busy),
        .frame_done(shift_done)
    );

    always_comb
    begin
        hold_next = hold_reg;
        hold_full_next = hold_full_reg;
        rdata_next = 8'h00;
        if (load_shift)
        begin
            hold_full_next = 1'b0;
        end
        if (reg_write && hits(reg_addr, AST_TX_HOLD))
        begin
            hold_next.ninth = tx_status_reg[AST_NINTH_POS];
            hold_next.low = reg_wdata;
            hold_full_next = 1'b1;
        end
        if (!tx_on_next)
        begin
            hold_full_next = 1'b0;
        end
        flag_next = tx_on_next && !hold_full_next;
        irq_next = flag_next
            && irq_en_next[AST_TX_IRQ_POS]
            && irq_ctrl_next[AST_GLOBAL_POS]
            && irq_ctrl_next[AST_PERIPH_POS];
        oe_next = rx_status_next[AST_PORT_ON_POS];
        out_next = serial_port_on ? (shift_line ^ invert_eff) : AST_MARK;
        restart_next = load_shift;
        if (reg_read)
        begin
            if (hits(reg_addr, AST_TX_STATUS))
            begin
                rdata_next = tx_status_reg;
                rdata_next[AST_EMPTY_POS] = !shift_busy;
            end
            else if (hits(reg_addr, AST_RX_STATUS))
            begin
                rdata_next = rx_status_reg;
            end
            else if (hits(reg_addr, AST_BAUD_CTRL))
            begin
                rdata_next = baud_ctrl_reg;
            end
            else if (hits(reg_addr, AST_TX_HOLD))
            begin
                rdata_next = hold_reg.low;
            end
            else if (hits(reg_addr, AST_DIV_HIGH))
            begin
                rdata_next = div_high_reg;
            end
            else if (hits(reg_addr, AST_DIV_LOW))
            begin
                rdata_next = div_low_reg;
            end
            else if (hits(reg_addr, AST_IRQ_FLAGS))
            begin
                rdata_next[AST_TX_IRQ_POS] = flag_reg;
            end
            else if (hits(reg_addr, AST_IRQ_EN))
            begin
                rdata_next = irq_en_reg;
            end
            else if (hits(reg_addr, AST_IRQ_PRIO))
            begin
                rdata_next = irq_prio_reg;
            end
            else if (hits(reg_addr, AST_IRQ_CTRL))
            begin
                rdata_next = irq_ctrl_reg;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            hold_reg <= '0;
            hold_full_reg <= 1'b0;
            flag_reg <= 1'b0;
            rdata_reg <= 8'h00;
            out_reg <= AST_MARK;
            oe_reg <= 1'b0;
            irq_reg <= 1'b0;
            restart_reg <= 1'b0;
        end
        else
        begin
            hold_reg <= hold_next;
            hold_full_reg <= hold_full_next;
            flag_reg <= flag_next;
            rdata_reg <= rdata_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            irq_reg <= irq_next;
            restart_reg <= restart_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign baud_cfg.divisor = {div_high_reg, div_low_reg};
    assign baud_cfg.high_speed = tx_status_reg[AST_SPEED_POS];
    assign baud_cfg.wide_counter = baud_ctrl_reg[AST_WIDE_POS];
    assign baud_restart = restart_reg;
    assign serial_out_pin = out_reg;
    assign serial_out_oe = oe_reg;
    assign tx_irq = irq_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    port_off_idle_a: assert property (
        (!serial_port_on && !rx_status_next[AST_PORT_ON_POS])
        |=> (!serial_out_oe && serial_out_pin == AST_MARK))
        else $error("Port off does not idle the pin.");
    port_on_drive_a: assert property (
        (serial_port_on && $past(serial_port_on)) |-> serial_out_oe)
        else $error("Port on but pin not driven.");
    flag_set_a: assert property (
        (tx_on && !hold_full_reg) |-> flag_reg)
        else $error("Empty flag low while holding empty.");
    flag_clear_a: assert property (
        (!tx_on || hold_full_reg) |-> !flag_reg)
        else $error("Empty flag high while holding full.");
    enable_flag_a: assert property (
        (reg_write && hits(reg_addr, AST_TX_STATUS) && reg_wdata[AST_ENABLE_POS]
        && !reg_wdata[AST_CLOCKED_POS] && serial_port_on && !hold_full_reg)
        |=> flag_reg)
        else $error("Enable did not set the empty flag.");
    write_flag_a: assert property (
        (reg_write && hits(reg_addr, AST_TX_HOLD) && tx_on && shift_busy && !hold_full_reg)
        |-> flag_reg ##1 !flag_reg)
        else $error("Empty flag timing after write is wrong.");
    idle_load_a: assert property (
        (reg_write && hits(reg_addr, AST_TX_HOLD) && tx_on && !shift_busy
        && !hold_full_reg && $stable(tx_status_reg)) |-> ##2 shift_busy)
        else $error("Idle shifter was not loaded at once.");
    queued_load_a: assert property (
        (shift_done && hold_full_reg && tx_on && !reg_write)
        |=> (shift_busy && !hold_full_reg))
        else $error("Queued character not loaded after stop.");
    idle_level_a: assert property (
        (serial_port_on && !shift_busy) |=> (serial_out_pin == (AST_MARK ^ $past(invert_eff))))
        else $error("Idle level has the wrong polarity.");
    irq_gate_a: assert property (
        (!flag_reg || !irq_en_reg[AST_TX_IRQ_POS]) |-> !tx_irq)
        else $error("Interrupt without flag and enable.");
    irq_raise_a: assert property (
        (flag_reg && irq_en_reg[AST_TX_IRQ_POS] && irq_ctrl_reg[AST_GLOBAL_POS]
        && irq_ctrl_reg[AST_PERIPH_POS]) |-> tx_irq)
        else $error("Enabled interrupt was not raised.");
    flag_write_a: assert property (
        (reg_write && hits(reg_addr, AST_IRQ_FLAGS) && !load_shift) |=> $stable(flag_reg))
        else $error("Software write changed the empty flag.");
    load_start_a: assert property (
        load_shift |=> (baud_restart && shift_busy))
        else $error("Loaded character did not start a frame.");
    ninth_carry_a: assert property (
        (reg_write && hits(reg_addr, AST_TX_HOLD))
        |=> (hold_reg.ninth == $past(tx_status_reg[AST_NINTH_POS])))
        else $error("Ninth bit not carried with the character.");

    back_to_back_c: cover property (shift_done && hold_full_reg && tx_on);
    nine_bit_c: cover property (load_shift && tx_status_reg[AST_NINE_POS] && hold_reg.ninth);
    irq_rise_c: cover property ($rose(tx_irq));
    inverted_c: cover property (shift_busy && invert_eff);
endmodule

/* tb_top.sv */
// Self-checking bench for the asynchronous serial transmitter.
// Assumes the receiver model and a bench-made bit tick of BIT_P cycles.
`timescale 1ns/1ps
module tb_top
    import ast_pkg::*;
;
    localparam int BIT_P = 16;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic bit_tick = 1'b0;
    ast_baud_s baud_cfg;
    logic baud_restart;
    logic pin;
    logic oe;
    logic tx_irq;
    logic inv_b = 1'b0;
    logic nine_b = 1'b0;
    logic [8:0] rx_char;
    logic rx_stop_ok;
    logic [7:0] rx_count;
    logic [7:0] cnt = 8'h00;
    logic [31:0] seed = 32'h5B87;
    logic [7:0] a;
    logic [7:0] b;
    logic n9;
    int tcnt = 0;
    int fail_count = 0;
    int n_compared = 0;

    always #20 mclk = ~mclk;

    // Bit tick generator, restarted at each frame start.
    always @(posedge mclk)
    begin
        if (baud_restart || tcnt == BIT_P - 1)
            tcnt <= 0;
        else
            tcnt <= tcnt + 1;
        bit_tick <= (tcnt == BIT_P - 1) && !baud_restart;
    end

    ast_uart_tx i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .bit_tick(bit_tick), .baud_cfg(baud_cfg),
        .baud_restart(baud_restart), .serial_out_pin(pin), .serial_out_oe(oe),
        .tx_irq(tx_irq));

    ast_rx_model #(.BIT_P(BIT_P)) i_rx (.mclk(mclk), .line(pin), .invert(inv_b),
        .nine(nine_b), .rx_char(rx_char), .rx_stop_ok(rx_stop_ok), .rx_count(rx_count));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    function automatic logic [7:0] txs(input logic nine, input logic ninth);
        return (8'h01 << AST_ENABLE_POS) | ({7'h00, nine} << AST_NINE_POS) | {7'h00, ninth};
    endfunction

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] ad, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1;
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    task automatic wait_rx(input logic [7:0] n);
        int k;
        for (k = 0; k < 600 && rx_count !== n; k++)
            @(posedge mclk);
        if (rx_count !== n)
        begin
            fail_count++;
            $display("[ERR] %0t no character arrived", $time);
            final_report();
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    initial
    begin
        idle(10);
        nrst <= 1'b1;
        idle(1);
        check({15'h0, pin}, 16'h1);
        check({15'h0, oe}, 16'h0);
        for (int j = 0; j < 11; j++)
            rdchk(j[3:0], (j == 0) ? 8'h02 : 8'h00);
        $display("test reset done");
        seed = xs(seed);
        wr(AST_BAUD_CTRL, 8'h08);
        wr(AST_DIV_HIGH, seed[15:8]);
        wr(AST_DIV_LOW, seed[7:0]);
        idle(1);
        check(baud_cfg.divisor, seed[15:0]);
        check({15'h0, baud_cfg.wide_counter}, 16'h1);
        wr(AST_RX_STATUS, 8'h80);
        idle(2);
        check({15'h0, oe}, 16'h1);
        rdchk(AST_IRQ_FLAGS, 8'h00);
        wr(AST_TX_STATUS, txs(1'b0, 1'b0));
        rdchk(AST_IRQ_FLAGS, 8'h10);
        wr(AST_IRQ_FLAGS, 8'h00);
        rdchk(AST_IRQ_FLAGS, 8'h10);
        rdchk(AST_TX_STATUS, 8'h22);
        $display("test setup done");
        for (int j = 0; j < 3; j++)
        begin
            seed = xs(seed);
            a = (j == 0) ? 8'h00 : seed[7:0];
            b = (j == 0) ? 8'hFF : seed[15:8];
            wr(AST_TX_HOLD, a);
            wr(AST_TX_HOLD, b);
            rdchk(AST_IRQ_FLAGS, 8'h00);
            rdchk(AST_TX_STATUS, 8'h20);
            wait_rx(cnt + 8'h01);
            check({7'h0, rx_char}, {8'h00, a});
            check({15'h0, rx_stop_ok}, 16'h1);
            wait_rx(cnt + 8'h02);
            check({7'h0, rx_char}, {8'h00, b});
            cnt = cnt + 8'h02;
            idle(BIT_P);
            rdchk(AST_TX_STATUS, 8'h22);
            rdchk(AST_IRQ_FLAGS, 8'h10);
        end
        $display("test back_to_back done");
        nine_b <= 1'b1;
        for (int j = 0; j < 3; j++)
        begin
            seed = xs(seed);
            n9 = (j == 0) ? 1'b1 : seed[16];
            wr(AST_TX_STATUS, txs(1'b1, n9));
            wr(AST_TX_HOLD, seed[7:0]);
            wait_rx(cnt + 8'h01);
            check({7'h0, rx_char}, {7'h00, n9, seed[7:0]});
            cnt = cnt + 8'h01;
            idle(BIT_P);
        end
        wr(AST_TX_STATUS, txs(1'b0, 1'b0));
        nine_b <= 1'b0;
        $display("test nine_bit done");
        inv_b <= 1'b1;
        wr(AST_BAUD_CTRL, 8'h10);
        idle(4);
        check({15'h0, pin}, 16'h0);
        seed = xs(seed);
        wr(AST_TX_HOLD, seed[7:0]);
        wait_rx(cnt + 8'h01);
        check({7'h0, rx_char}, {8'h00, seed[7:0]});
        cnt = cnt + 8'h01;
        idle(BIT_P);
        wr(AST_BAUD_CTRL, 8'h00);
        inv_b <= 1'b0;
        idle(4);
        check({15'h0, pin}, 16'h1);
        $display("test invert done");
        wr(AST_IRQ_EN, 8'h10);
        wr(AST_IRQ_CTRL, 8'hC0);
        idle(2);
        check({15'h0, tx_irq}, 16'h1);
        wr(AST_IRQ_EN, 8'h00);
        idle(2);
        check({15'h0, tx_irq}, 16'h0);
        rdchk(AST_IRQ_FLAGS, 8'h10);
        $display("test irq done");
        wr(AST_TX_HOLD, 8'h5A);
        wr(AST_TX_HOLD, 8'hC3);
        idle(3 * BIT_P);
        wr(AST_RX_STATUS, 8'h00);
        idle(3);
        check({15'h0, pin}, 16'h1);
        check({15'h0, oe}, 16'h0);
        rdchk(AST_TX_STATUS, 8'h22);
        idle(400);
        cnt = rx_count;
        wr(AST_RX_STATUS, 8'h80);
        idle(400);
        check({8'h00, rx_count}, {8'h00, cnt});
        $display("test port_off done");
        wr(AST_TX_STATUS, txs(1'b0, 1'b0) | 8'h14);
        wr(AST_BAUD_CTRL, 8'h10);
        wr(AST_TX_HOLD, 8'hA5);
        idle(300);
        check({8'h00, rx_count}, {8'h00, cnt});
        check({15'h0, pin}, 16'h1);
        check({15'h0, pin}, 16'h1);
        check({15'h0, baud_cfg.high_speed}, 16'h1);
        $display("test clocked_mode done");
        final_report();
    end
endmodule
